// [board_strap_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Board side: strap drivers and pulled-up reset pin
module board_strap_model (
    input wire logic strapDisable,
    input wire logic [3:0] bootSelect,
    input wire logic externalResetOut_n,
    input wire logic externalResetOe_n,
    output logic pllDisablePin_n,
    output logic processorModePin,
    output logic [3:0] bootModePins,
    output logic resetPinLevel
);
    // Straps change only with the bench's reset, so they stay put well past every hold window
    assign pllDisablePin_n = !strapDisable;
    assign processorModePin = 1'b0;
    assign bootModePins = bootSelect;
    // Open drain with pull-up: high unless the device pulls down
    assign resetPinLevel = externalResetOe_n ? 1'b1 : externalResetOut_n;
endmodule : board_strap_model
`default_nettype wire

// [clock_mode_reset_sequencer.sv]
// Behaviour
// - A low PLL disable strap at reset shuts the PLL off and passes the input clock straight through.
// - Without the disable strap the block powers up in bypass, system clock at half the input.
// - Without the disable strap a non-zero multiplier write enables the PLL; input times n over two is modelled at input rate.
// - After enabling or reprogramming, lock is reported within 131072 input periods.
// - A watchdog reset drives the reset pin low for 512 input periods.
// - The external bus is valid 32 input periods after the reset pin goes high.
// - Both divide bits reset to one, so the clock output is the system clock over four.
// - The boot sequence waits 1260 system cycles at half input rate before sampling boot pins.
// - The sampled boot pins choose a memory destination or a boot function.
// - The fastest clock output, with both divide bits clear, toggles every input period in every clock mode.
`timescale 1ns/1ps
`default_nettype none
module clock_mode_reset_sequencer #(
    parameter int MULT_WIDTH = 4,
    parameter int BOOT_WIDTH = 4,
    parameter int LOCK_PERIODS = clock_seq_pkg::PLL_LOCK_PERIODS,
    parameter int WD_PERIODS = clock_seq_pkg::WD_RESET_PERIODS,
    parameter int BUS_PERIODS = clock_seq_pkg::BUS_VALID_PERIODS,
    parameter int BOOT_PERIODS = clock_seq_pkg::BOOT_INPUT_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic pllDisablePin_n,
    input wire logic processorModePin,
    input wire logic [BOOT_WIDTH-1:0] bootModePins,
    input wire logic watchdogReset,
    input wire logic [3:0] address,
    input wire logic [15:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [15:0] readData,
    output logic [1:0] clockMode,
    output logic [MULT_WIDTH-1:0] multiplier,
    output logic pllLocked,
    output logic systemClockEnable,
    output logic clockOutputPin,
    output logic externalResetOut_n,
    output logic externalResetOe_n,
    output logic busValid,
    output logic bootSampled,
    output logic bootToMemory,
    output logic [BOOT_WIDTH-1:0] bootFunction,
    output logic processorMode
);
    // ==========================================
    // Pin synchronisers
    logic [1:0] disSync;
    logic [1:0] pmSync;
    logic [1:0] wdSync;
    logic [1:0] rstPinSync;
    logic [BOOT_WIDTH-1:0] bootSync1;
    logic [BOOT_WIDTH-1:0] bootSync2;

    // Every strap and the watchdog request come from the board or another block.
    // They may change at any time relative to mclk, so each passes two flops.
    // The device's own reset output, not the pin, is read back through the same kind of chain.
    // This keeps one sampling point for the sequencer, but a low driven by the board is not seen.
    // The cost is two cycles of latency on every pin, which the sequence absorbs.
    // No logic may tap the first stage; it can still be settling.

    // Two flops on every pin; only stage two is read by logic
    always_ff @(posedge mclk) begin
        disSync <= {disSync[0], pllDisablePin_n};
        pmSync <= {pmSync[0], processorModePin};
        wdSync <= {wdSync[0], watchdogReset};
        rstPinSync <= {rstPinSync[0], externalResetOut_n};
        bootSync1 <= bootModePins;
        bootSync2 <= bootSync1;
    end

    // ==========================================
    // State and registers
    clock_seq_pkg::seq_state_t state;
    clock_seq_pkg::seq_state_t next_state;
    logic [17:0] count;
    logic [17:0] lockCount;
    logic strapDisabled;
    logic timingDiv;
    logic clockOutDiv;
    logic [1:0] sysPhase;
    logic [2:0] outCount;
    logic pinReleased;

    // ==========================================
    // Register decode
    // Map, in words of 16 bits:
    //   0  multiplier n, low bits; zero selects bypass
    //   1  divide bits: bit 0 timing divide, bit 1 clock-out divide
    //   2  status: bus valid, locked, running, strap disabled, mode
    //   3  write bit 0 high to start a software watchdog reset
    //   4  boot result: to-memory flag above the sampled pins
    // Unmapped addresses read as zero and ignore writes.
    // Decoding is kept in named wires so the flops below stay short.
    wire writeMult = writeStrobe && (address == clock_seq_pkg::ADDR_MULT);
    wire writeCfg = writeStrobe && (address == clock_seq_pkg::ADDR_INTF_CFG);
    wire writeWdog = writeStrobe && (address == clock_seq_pkg::ADDR_WDOG);
    wire wdEvent = wdSync[1] || (writeWdog && writeData[0]);
    wire [MULT_WIDTH-1:0] newMult = writeData[MULT_WIDTH-1:0];
    wire [15:0] statusWord = {10'h000, busValid, pllLocked, state == clock_seq_pkg::SEQ_RUN,
        strapDisabled, clockMode};
    wire [15:0] bootWord = {{(15 - BOOT_WIDTH){1'b0}}, bootToMemory, bootFunction};
    wire [15:0] readMux =
        (address == clock_seq_pkg::ADDR_MULT) ? {{(16 - MULT_WIDTH){1'b0}}, multiplier} :
        (address == clock_seq_pkg::ADDR_INTF_CFG) ? {14'h0000, clockOutDiv, timingDiv} :
        (address == clock_seq_pkg::ADDR_STATUS) ? statusWord :
        (address == clock_seq_pkg::ADDR_BOOT) ? bootWord : 16'h0000;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            readData <= 16'h0000;
        end else begin
            readData <= readStrobe ? readMux : 16'h0000;
        end
    end

    // ==========================================
    // Strap capture and clock mode selection
    // Strap is caught in the first hold cycle after reset or a watchdog reset, once its synchroniser has settled
    always_ff @(posedge mclk) begin
        if (reset) begin
            strapDisabled <= 1'b0;
        end else if (state == clock_seq_pkg::SEQ_HOLD && count == 18'h0_0000) begin
            strapDisabled <= !disSync[1];
        end
    end

    // The strap is the only way into the disabled mode.
    // Software cannot leave it either: multiplier writes are dropped.
    // This keeps the straight-through path free of a half-programmed PLL.

    // Multiplier register; zero means bypass
    always_ff @(posedge mclk) begin
        if (reset) begin
            multiplier <= MULT_WIDTH'(clock_seq_pkg::MULT_RESET);
        end else if (writeMult && !strapDisabled) begin
            multiplier <= newMult;
        end
    end

    // Disabled ignores the multiplier; zero selects bypass
    assign clockMode = strapDisabled ? 2'(clock_seq_pkg::MODE_DISABLED) :
        (multiplier != '0) ? 2'(clock_seq_pkg::MODE_ENABLED) :
        2'(clock_seq_pkg::MODE_BYPASS);

    // Lock is only modelled as a bounded wait after each change.
    // A rewrite during the wait restarts it, so software always sees the full time.
    // Outside the enabled mode there is nothing to lock, so the flag reads high.

    // Lock counter restarts on every accepted multiplier write
    always_ff @(posedge mclk) begin
        if (reset) begin
            lockCount <= 18'h0_0000;
            pllLocked <= 1'b0;
        end else if (writeMult && !strapDisabled) begin
            lockCount <= 18'h0_0000;
            pllLocked <= (newMult == '0);
        end else if (clockMode != 2'(clock_seq_pkg::MODE_ENABLED)) begin
            pllLocked <= 1'b1;
        end else if (!pllLocked) begin
            lockCount <= lockCount + 18'h0_0001;
            pllLocked <= (lockCount == 18'(LOCK_PERIODS - 1));
        end
    end

    // ==========================================
    // System clock enable and output divider
    // Full rate only when disabled (straight through) or PLL running
    always_ff @(posedge mclk) begin
        if (reset) begin
            sysPhase <= 2'b00;
        end else begin
            sysPhase <= sysPhase + 2'b01;
        end
    end
    // Multiplied rate is modelled at input rate; true multiplication is analogue
    assign systemClockEnable = (clockMode == 2'(clock_seq_pkg::MODE_BYPASS)) ? sysPhase[0] : 1'b1;

    // Divide bits reset to one
    always_ff @(posedge mclk) begin
        if (reset) begin
            timingDiv <= clock_seq_pkg::TIMING_DIV_RESET;
            clockOutDiv <= clock_seq_pkg::CLKOUT_DIV_RESET;
        end else if (writeCfg) begin
            timingDiv <= writeData[clock_seq_pkg::TIMING_DIV_BIT];
            clockOutDiv <= writeData[clock_seq_pkg::CLKOUT_DIV_BIT];
        end
    end

    // The output period is the system period times one, two or four.
    // A half period is therefore half, one or two system cycles.
    // Two cycles need a small counter; one cycle toggles on every system tick.
    // Half a system cycle is only possible in bypass, where two input edges make one system cycle.
    // Limitation: at full rate with both bits clear the pin runs at half the system clock.
    wire [2:0] halfLimit = (timingDiv && clockOutDiv) ? 3'b001 : 3'b000;
    wire outTick = (!timingDiv && !clockOutDiv) || systemClockEnable;

    // Output toggles after the chosen number of system cycles
    always_ff @(posedge mclk) begin
        if (reset) begin
            outCount <= 3'b000;
            clockOutputPin <= 1'b0;
        end else if (outTick) begin
            if (outCount >= halfLimit) begin
                outCount <= 3'b000;
                clockOutputPin <= !clockOutputPin;
            end else begin
                outCount <= outCount + 3'b001;
            end
        end
    end

    // ==========================================
    // Reset sequence
    // Hold waits for the device's own reset output to read back high, then the bus delay runs.
    // The boot delay follows, and the boot pins are sampled as it ends.
    // A watchdog event from any other state drives the pin low for a fixed time.
    // It then returns to hold, so the whole sequence runs again.
    // All delays count input periods, since mclk stands for the input clock.
    // The boot delay is given in system cycles at half rate, hence twice as many input periods.

    // Next state; a watchdog event overrides every move except in watchdog reset
    always_comb begin
        next_state = state;
        case (state)
            clock_seq_pkg::SEQ_HOLD: begin
                if (pinReleased) next_state = clock_seq_pkg::SEQ_BUS_WAIT;
            end
            clock_seq_pkg::SEQ_BUS_WAIT: begin
                if (count == 18'(BUS_PERIODS - 1)) next_state = clock_seq_pkg::SEQ_BOOT_WAIT;
            end
            clock_seq_pkg::SEQ_BOOT_WAIT: begin
                if (count == 18'(BOOT_PERIODS - 1)) next_state = clock_seq_pkg::SEQ_RUN;
            end
            clock_seq_pkg::SEQ_RUN: begin
                next_state = clock_seq_pkg::SEQ_RUN;
            end
            clock_seq_pkg::SEQ_WD_RESET: begin
                if (count == 18'(WD_PERIODS - 1)) next_state = clock_seq_pkg::SEQ_HOLD;
            end
            default: next_state = clock_seq_pkg::SEQ_HOLD;
        endcase
        if (wdEvent && state != clock_seq_pkg::SEQ_WD_RESET) next_state = clock_seq_pkg::SEQ_WD_RESET;
    end

    // Own reset output read back; a board driver holding the pin low is not seen
    assign pinReleased = rstPinSync[1];

    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= clock_seq_pkg::SEQ_HOLD;
            count <= 18'h0_0000;
        end else begin
            state <= next_state;
            count <= (next_state != state) ? 18'h0_0000 : count + 18'h0_0001;
        end
    end

    // The pin is shared with the board's reset driver.
    // Only a low is ever driven; a pull-up on the board supplies the high.
    // A board that holds the pin low does not keep the sequence in hold.

    // Open-drain reset pin: enable low drives it low during watchdog reset
    assign externalResetOut_n = (state != clock_seq_pkg::SEQ_WD_RESET) && !reset;
    assign externalResetOe_n = !(state == clock_seq_pkg::SEQ_WD_RESET);

    // Bus valid once the post-release delay has passed
    always_ff @(posedge mclk) begin
        if (reset) begin
            busValid <= 1'b0;
        end else begin
            busValid <= (next_state == clock_seq_pkg::SEQ_BOOT_WAIT) || (next_state == clock_seq_pkg::SEQ_RUN);
        end
    end

    // The processor mode is caught as the pin is released, inside its hold time.
    // The boot pins are caught once, at the end of the boot delay.
    // Board changes after that point do not reach the result.
    // All pins high selects memory; any other pattern names a boot function.

    // Processor mode sampled at pin release, boot pins at the end of the boot wait
    always_ff @(posedge mclk) begin
        if (reset) begin
            bootSampled <= 1'b0;
            bootToMemory <= 1'b0;
            bootFunction <= '0;
            processorMode <= 1'b0;
        end else if (state == clock_seq_pkg::SEQ_HOLD && pinReleased) begin
            processorMode <= pmSync[1];
            bootSampled <= 1'b0;
        end else if (state == clock_seq_pkg::SEQ_BOOT_WAIT && next_state == clock_seq_pkg::SEQ_RUN) begin
            bootSampled <= 1'b1;
            bootToMemory <= (bootSync2 == '1);
            bootFunction <= bootSync2;
        end else if (state == clock_seq_pkg::SEQ_WD_RESET) begin
            bootSampled <= 1'b0;
        end
    end
endmodule : clock_mode_reset_sequencer
`default_nettype wire

// [clock_mode_reset_sequencer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module clock_mode_reset_sequencer_tb_top;
    localparam int LOCK = 64;
    localparam int WD = 16;
    localparam int BUS = 4;
    localparam int BOOT = 20;
    logic mclk, reset, watchdogReset, writeStrobe, readStrobe, strapDisable;
    logic [3:0] address, bootSelect, multiplier, bootModePins, bootFunction;
    logic [15:0] writeData, readData;
    logic [1:0] clockMode;
    logic pllLocked, systemClockEnable, clockOutputPin, externalResetOut_n, externalResetOe_n, busValid;
    logic bootSampled, bootToMemory, processorMode, pllDisablePin_n, processorModePin, resetPinLevel;
    int errCount = 0;
    int nTests = 0;
    int n;
    // ==========================================
    // Clock, device and board
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    clock_mode_reset_sequencer #(.LOCK_PERIODS(LOCK), .WD_PERIODS(WD), .BUS_PERIODS(BUS), .BOOT_PERIODS(BOOT)) i_dut (
        .mclk, .reset, .pllDisablePin_n, .processorModePin, .bootModePins, .watchdogReset, .address, .writeData,
        .writeStrobe, .readStrobe, .readData, .clockMode, .multiplier, .pllLocked, .systemClockEnable,
        .clockOutputPin, .externalResetOut_n, .externalResetOe_n, .busValid, .bootSampled, .bootToMemory,
        .bootFunction, .processorMode);
    board_strap_model i_board (.strapDisable, .bootSelect, .externalResetOut_n, .externalResetOe_n,
        .pllDisablePin_n, .processorModePin, .bootModePins, .resetPinLevel);
    // ==========================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finalReport();
        $display("Checks %0d, mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finalReport
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge mclk);
        writeStrobe <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge mclk);
        readStrobe <= 1'b0;
        #1;
        check(readData, exp);
    endtask : rd
    // Bounded wait; running out counts as a failure and ends the run
    task automatic waitLevel(ref logic s, input logic lv);
        n = 0;
        while (s !== lv && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 3000) begin
            errCount++;
            finalReport();
        end
    endtask : waitLevel
    // Half period of the clock output, in input cycles
    task automatic clkHalf(input logic [15:0] exp);
        logic p;
        waitLevel(clockOutputPin, !clockOutputPin);
        p = clockOutputPin;
        waitLevel(clockOutputPin, !p);
        check(16'(n), exp);
    endtask : clkHalf
    // ==========================================
    // Scenarios
    task automatic scPowerUp();
        waitLevel(busValid, 1'b1);
        check(16'(n >= BUS && n <= BUS + 8), 16'h0001);
        check(16'(clockMode), 16'h0001);
        rd(4'h1, 16'h0003);
        clkHalf(16'h0004);
        waitLevel(bootSampled, 1'b1);
        check(16'(n >= BOOT - 14 && n <= BOOT + 4), 16'h0001);
        check(16'(bootToMemory), 16'h0001);
        wr(4'h1, 16'h0001);
        clkHalf(16'h0002);
        rd(4'hF, 16'h0000);
    endtask : scPowerUp
    task automatic scMultiply();
        wr(4'h0, 16'h0005);
        check(16'(clockMode), 16'h0002);
        check(16'(pllLocked), 16'h0000);
        waitLevel(pllLocked, 1'b1);
        check(16'(n <= LOCK + 4), 16'h0001);
        clkHalf(16'h0001);
        rd(4'h0, 16'h0005);
        wr(4'h0, 16'h0000);
        check(16'(clockMode), 16'h0001);
    endtask : scMultiply
    task automatic scWatchdog();
        wr(4'h3, 16'h0001);
        waitLevel(resetPinLevel, 1'b0);
        waitLevel(resetPinLevel, 1'b1);
        check(16'(n), 16'(WD));
        waitLevel(busValid, 1'b1);
        check(16'(n >= BUS && n <= BUS + 8), 16'h0001);
        @(posedge mclk);
        watchdogReset <= 1'b1;
        @(posedge mclk);
        watchdogReset <= 1'b0;
        waitLevel(resetPinLevel, 1'b0);
        waitLevel(resetPinLevel, 1'b1);
        check(16'(n), 16'(WD));
    endtask : scWatchdog
    task automatic scDisabled();
        @(posedge mclk);
        strapDisable <= 1'b1;
        bootSelect <= 4'h5;
        reset <= 1'b1;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        wr(4'h0, 16'h0003);
        check(16'(clockMode), 16'h0000);
        check(16'(systemClockEnable), 16'h0001);
        waitLevel(bootSampled, 1'b1);
        check({11'h000, bootToMemory, bootFunction}, 16'h0005);
        check(16'(processorMode), 16'h0000);
        rd(4'h4, 16'h0005);
        rd(4'h2, 16'h003C);
    endtask : scDisabled
    // ==========================================
    // Main sequence and hang guard
    initial begin
        strapDisable = 1'b0;
        bootSelect = 4'hF;
        watchdogReset = 1'b0;
        address = 4'h0;
        writeData = 16'h0000;
        writeStrobe = 1'b0;
        readStrobe = 1'b0;
        reset = 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        scPowerUp();
        scMultiply();
        scWatchdog();
        scDisabled();
        finalReport();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errCount++;
        finalReport();
    end
endmodule : clock_mode_reset_sequencer_tb_top
`default_nettype wire

// [clock_seq_pkg.sv]
package clock_seq_pkg;
    // ==========================================
    // Timing figures, in input clock periods except BOOT_SYS_CYCLES, in system cycles
    localparam int PLL_LOCK_PERIODS = 131072;
    localparam int OLD_LOCK_PERIODS = 4096;
    localparam int WD_RESET_PERIODS = 512;
    localparam int BUS_VALID_PERIODS = 32;
    localparam int WARM_RESET_MIN_PERIODS = 8;
    localparam int STABLE_CLOCK_MIN_PERIODS = 8;
    localparam int STRAP_HOLD_PERIODS = 16;
    localparam int BOOT_SYS_CYCLES = 1260;
    localparam int BOOT_PIN_HOLD_PERIODS = 2520;
    // Input clock cycles for the boot delay (system clock is half input)
    localparam int BOOT_INPUT_CYCLES = BOOT_SYS_CYCLES * 2;

    // ==========================================
    // Register offsets and reset values
    localparam logic [3:0] ADDR_MULT = 4'h0;
    localparam logic [3:0] ADDR_INTF_CFG = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_WDOG = 4'h3;
    localparam logic [3:0] ADDR_BOOT = 4'h4;
    localparam logic [3:0] MULT_RESET = 4'h0;
    localparam logic TIMING_DIV_RESET = 1'b1;
    localparam logic CLKOUT_DIV_RESET = 1'b1;
    localparam int TIMING_DIV_BIT = 0;
    localparam int CLKOUT_DIV_BIT = 1;

    // ==========================================
    // Clock path modes
    typedef enum logic [1:0] {
        MODE_DISABLED = 2'b00,
        MODE_BYPASS = 2'b01,
        MODE_ENABLED = 2'b10
    } clock_mode_t;

    // Reset sequencing states
    typedef enum logic [2:0] {
        SEQ_HOLD = 3'b000,
        SEQ_BUS_WAIT = 3'b001,
        SEQ_BOOT_WAIT = 3'b010,
        SEQ_RUN = 3'b011,
        SEQ_WD_RESET = 3'b100
    } seq_state_t;
endpackage : clock_seq_pkg

// [clock_seq_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker for the clock and reset sequencer
module clock_seq_props #(
    parameter int MULT_WIDTH = 4,
    parameter int BOOT_WIDTH = 4,
    parameter int LOCK_PERIODS = 64,
    parameter int WD_PERIODS = 16,
    parameter int BUS_PERIODS = 4,
    parameter int BOOT_PERIODS = 20
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [BOOT_WIDTH-1:0] bootModePins,
    input wire logic [3:0] address,
    input wire logic [15:0] writeData,
    input wire logic writeStrobe,
    input wire logic [1:0] clockMode,
    input wire logic [MULT_WIDTH-1:0] multiplier,
    input wire logic pllLocked,
    input wire logic systemClockEnable,
    input wire logic externalResetOut_n,
    input wire logic externalResetOe_n,
    input wire logic busValid,
    input wire logic bootSampled,
    input wire logic bootToMemory
);
    localparam int LOCK_MAX = LOCK_PERIODS + 4;
    localparam int BUS_MAX = BUS_PERIODS + 6;
    localparam int BOOT_MIN = BOOT_PERIODS - 2;
    localparam int BOOT_MAX = BOOT_PERIODS + 4;
    logic [15:0] lowCnt;
    // Cycles the watchdog has held the pin down; cleared whenever released
    always_ff @(posedge mclk) begin
        lowCnt <= (reset || externalResetOe_n) ? 16'h0000 : lowCnt + 16'h0001;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // ==========================================
    // Clock path
    mode_select_a: assert property (clockMode != 2'h0 |->
        clockMode == ((multiplier != '0) ? 2'h2 : 2'h1)) else $error("mode does not follow multiplier");
    bypass_half_a: assert property ((!$past(reset) && clockMode == 2'h1 && $past(clockMode) == 2'h1)
        |-> systemClockEnable != $past(systemClockEnable)) else $error("bypass clock not halved");
    full_rate_a: assert property (clockMode != 2'h1 |-> systemClockEnable)
        else $error("clock not full rate");
    lock_bound_a: assert property ((writeStrobe && address == 4'h0 && writeData[3:0] != 4'h0 && clockMode != 2'h0)
        |=> !pllLocked ##[1:LOCK_MAX] pllLocked) else $error("lock not in time");
    // ==========================================
    // Reset sequencing
    wd_drive_a: assert property (!externalResetOe_n |-> !externalResetOut_n)
        else $error("reset pin driven high");
    wd_length_a: assert property ($rose(externalResetOe_n) |-> lowCnt == WD_PERIODS)
        else $error("watchdog pulse length wrong");
    bus_valid_a: assert property ($rose(externalResetOut_n) |->
        !busValid ##[BUS_PERIODS:BUS_MAX] busValid) else $error("bus valid timing wrong");
    boot_delay_a: assert property ($rose(busValid) |-> ##[BOOT_MIN:BOOT_MAX] bootSampled)
        else $error("boot sample late");
    boot_branch_a: assert property ($rose(bootSampled) |-> bootToMemory == (&bootModePins))
        else $error("boot branch wrong");
    cover property ($rose(bootSampled));
    cover property ($rose(externalResetOe_n));
    cover property (clockMode == 2'h2 && pllLocked);
endmodule : clock_seq_props
bind clock_mode_reset_sequencer clock_seq_props #(.MULT_WIDTH(MULT_WIDTH), .BOOT_WIDTH(BOOT_WIDTH),
    .LOCK_PERIODS(LOCK_PERIODS), .WD_PERIODS(WD_PERIODS), .BUS_PERIODS(BUS_PERIODS), .BOOT_PERIODS(BOOT_PERIODS))
    i_props (.mclk, .reset, .bootModePins, .address, .writeData, .writeStrobe, .clockMode, .multiplier, .pllLocked,
    .systemClockEnable, .externalResetOut_n, .externalResetOe_n, .busValid, .bootSampled, .bootToMemory);
`default_nettype wire
